/* dv/card_seq_chk.sv */
// Purpose: Port checks for the card sequencer
// Assumes: One clock domain, synchronous reset
// Notes:   Bound to every card_seq instance
`timescale 1ns/10ps
`include "card_seq_consts.svh"

module card_seq_chk #(
    parameter int unsigned DEBOUNCE_CYCLES = `DEBOUNCE_CYC
)(
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic reset_in,
    // Host and monitors
    input wire logic session_request_n_in,
    input wire logic event_n_out,
    input wire logic card_presence_switch_in,
    input wire card_seq_pkg::fault_t fault_in,
    input wire logic pin_current_limit_in,
    input wire card_seq_pkg::card_pins_t active_pins_in,
    // Card side
    input wire logic card_reset_out,
    input wire logic card_clock_out,
    input wire logic card_data_line_out,
    input wire logic card_aux_line_a_out,
    input wire logic card_aux_line_b_out,
    input wire logic card_supply_out,
    input wire logic deact_busy_out
);
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (reset_in);

    int unsigned low_cnt_ff;
    int unsigned pres_cnt_ff;

    // Cycles since card reset went low in deactivation
    always_ff @(posedge core_clk_in)
        low_cnt_ff <= (deact_busy_out && !card_reset_out) ?
                      low_cnt_ff + 1 : 0;

    // Cycles the raw presence switch has stayed high
    always_ff @(posedge core_clk_in)
        pres_cnt_ff <= card_presence_switch_in ? pres_cnt_ff + 1 : 0;

    sequence lines_low;
        !card_data_line_out && !card_aux_line_a_out && !card_aux_line_b_out;
    endsequence
    sequence clk_fall;
        deact_busy_out && $fell(card_clock_out);
    endsequence

    a_release_deact: assert property (
        $rose(session_request_n_in) && card_supply_out && !deact_busy_out
        |-> ##[1:5] deact_busy_out) else $error("no deactivation");
    a_reset_first: assert property (
        $rose(deact_busy_out) |-> ##[0:1] !card_reset_out)
        else $error("reset not low first");
    a_clk_delay: assert property (
        clk_fall |-> low_cnt_ff == `RST_TO_CLK_CYC)
        else $error("clock low at wrong delay");
    a_step_order: assert property (
        clk_fall |-> card_supply_out ##1 (lines_low ##0 card_supply_out)
        ##1 !card_supply_out) else $error("bad step order");
    a_supply_last: assert property (
        $fell(card_supply_out) |-> lines_low ##0
        (!card_reset_out && !card_clock_out)) else $error("supply early");
    a_no_card: assert property (
        (!card_presence_switch_in)[*5] |-> !event_n_out)
        else $error("event high without card");
    a_uv_event: assert property (
        (fault_in.logic_uv)[*4] |-> !event_n_out)
        else $error("event high in undervoltage");
    a_fault_deact: assert property (
        $rose(|fault_in) && card_supply_out && !deact_busy_out
        |-> ##[1:5] (deact_busy_out && !event_n_out))
        else $error("fault not handled");
    a_debounce_wait: assert property (
        $rose(event_n_out) |-> pres_cnt_ff >= DEBOUNCE_CYCLES)
        else $error("event before debounce");
    a_limit_quiet: assert property (
        (!(|fault_in) && card_presence_switch_in)[*3] ##0
        (pin_current_limit_in && event_n_out) |=> event_n_out)
        else $error("current limit reported");
    a_power_quiet: assert property (
        disable iff (1'b0) reset_in |=> !event_n_out && !card_supply_out)
        else $error("outputs active in reset");
endmodule

bind card_seq card_seq_chk #(.DEBOUNCE_CYCLES(DEBOUNCE_CYCLES))
    card_seq_chk_inst (.core_clk_in, .reset_in, .session_request_n_in,
    .event_n_out, .card_presence_switch_in, .fault_in,
    .pin_current_limit_in, .active_pins_in, .card_reset_out,
    .card_clock_out, .card_data_line_out, .card_aux_line_a_out,
    .card_aux_line_b_out, .card_supply_out, .deact_busy_out);

/* dv/card_seq_tb_top.sv */
// Purpose: Self-checking bench for the card sequencer
// Assumes: Debounce shortened to DB cycles
// Notes:   Inputs change on the falling clock edge
`timescale 1ns/10ps
`include "card_seq_consts.svh"

module card_seq_tb_top;
    localparam int DB = 20;
    logic core_clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic want = 1'b0, card = 1'b0, limit = 1'b0;
    logic req_n, event_n, busy, seen;
    logic rst_o, clk_o, dat_o, aux_a, aux_b, sup_o;
    card_seq_pkg::fault_t fault = '0;
    card_seq_pkg::card_pins_t pins = 6'h3f;
    int num_errors = 0;
    int comparisons = 0;

    always #50 core_clk_in = ~core_clk_in;

    card_seq #(.DEBOUNCE_CYCLES(DB)) card_seq_inst (
        .core_clk_in, .reset_in, .session_request_n_in(req_n),
        .event_n_out(event_n), .card_presence_switch_in(card),
        .fault_in(fault), .pin_current_limit_in(limit),
        .active_pins_in(pins), .card_reset_out(rst_o),
        .card_clock_out(clk_o), .card_data_line_out(dat_o),
        .card_aux_line_a_out(aux_a), .card_aux_line_b_out(aux_b),
        .card_supply_out(sup_o), .deact_busy_out(busy));
    host_model host_model_inst (.core_clk_in, .want_in(want),
        .event_n_in(event_n), .busy_in(busy),
        .session_request_n_out(req_n), .event_seen_out(seen));

    task automatic compare(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk_in);
    endtask

    task automatic wait_lvl(ref logic s, input logic v);
        for (int i = 0; i < 300 && s !== v; i++)
            @(negedge core_clk_in);
        compare(s, v);
    endtask

    task automatic deact_check;
        int n;
        wait_lvl(rst_o, 1'b0);
        n = 0;
        while (clk_o === 1'b1 && n < 300)
        begin
            cyc(1);
            n++;
        end
        compare(n, `RST_TO_CLK_CYC);
        compare({dat_o, sup_o}, 2'b11);
        cyc(1);
        compare({dat_o, aux_a, aux_b, sup_o}, 4'b0001);
        cyc(1);
        compare(sup_o, 1'b0);
        want = 1'b0;
        wait_lvl(busy, 1'b0);
    endtask

    task automatic t_insert;
        compare(event_n, 1'b0);
        card = 1'b1;
        cyc(DB);
        compare(event_n, 1'b0);
        wait_lvl(event_n, 1'b1);
    endtask

    task automatic t_close;
        want = 1'b1;
        wait_lvl(sup_o, 1'b1);
        cyc(4);
        compare({rst_o, clk_o, dat_o, aux_a, aux_b, sup_o}, pins);
        limit = 1'b1;
        cyc(10);
        compare(event_n, 1'b1);
        limit = 1'b0;
        want = 1'b0;
        deact_check();
        compare(event_n, 1'b1);
    endtask

    task automatic t_faults;
        for (int b = 0; b < 6; b++)
        begin
            want = 1'b1;
            wait_lvl(sup_o, 1'b1);
            fault = card_seq_pkg::fault_t'(6'h20 >> b);
            wait_lvl(event_n, 1'b0);
            deact_check();
            fault = '0;
            wait_lvl(event_n, 1'b1);
            cyc(1);
            compare(seen, 1'b1);
        end
    endtask

    task automatic t_uv_idle;
        fault.logic_uv = 1'b1;
        wait_lvl(event_n, 1'b0);
        fault.logic_uv = 1'b0;
        wait_lvl(event_n, 1'b1);
    endtask

    task automatic t_reset_mid;
        want = 1'b1;
        wait_lvl(sup_o, 1'b1);
        reset_in = 1'b1;
        want = 1'b0;
        cyc(2);
        compare({rst_o, clk_o, dat_o, sup_o, event_n, busy}, 6'h00);
        reset_in = 1'b0;
        compare(event_n, 1'b0);
        wait_lvl(event_n, 1'b1);
    endtask

    task automatic t_remove;
        want = 1'b1;
        wait_lvl(sup_o, 1'b1);
        card = 1'b0;
        wait_lvl(event_n, 1'b0);
        deact_check();
    endtask

    task automatic print_verdict;
        $display("num_errors=%0d comparisons=%0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial
    begin
        #2ms;
        num_errors++;
        print_verdict();
    end

    initial
    begin
        cyc(5);
        reset_in = 1'b0;
        cyc(3);
        t_insert();
        t_close();
        t_faults();
        t_uv_idle();
        t_reset_mid();
        t_remove();
        print_verdict();
    end
endmodule

/* dv/host_model.sv */
// Purpose: Host controller model on the session request line
// Assumes: Acts on the falling clock edge
// Notes:   Drops its request itself once deactivation starts
`timescale 1ns/10ps

module host_model (
    // Clock and bench control
    input  wire logic core_clk_in,
    input  wire logic want_in,
    // Block side
    input  wire logic event_n_in,
    input  wire logic busy_in,
    output logic      session_request_n_out,
    output logic      event_seen_out
);
    always @(negedge core_clk_in)
        session_request_n_out <= !want_in || busy_in;

    always @(negedge core_clk_in)
        if (session_request_n_out && !busy_in)
            event_seen_out <= event_n_in;
endmodule

/* hw/card_seq.sv */
// Purpose: Card session deactivation and fault supervision
// Assumes: Activation logic elsewhere supplies pin levels in session
// Notes:   All pins and fault flags arrive asynchronously
//          Event latched low after a session fault until idle
//          Current limiting stays local, never reported
`timescale 1ns/10ps
`include "card_seq_consts.svh"

module card_seq #(
    parameter int unsigned DEBOUNCE_CYCLES = `DEBOUNCE_CYC,
    parameter int unsigned DB_W            = 20
)(
    // Clock and reset
    input  wire logic                      core_clk_in,
    input  wire logic                      reset_in,
    // Host side
    input  wire logic                      session_request_n_in,
    output logic                           event_n_out,
    // Card presence and monitors (asynchronous)
    input  wire logic                      card_presence_switch_in,
    input  wire card_seq_pkg::fault_t      fault_in,
    input  wire logic                      pin_current_limit_in,
    // Activation levels for the card pins
    input  wire card_seq_pkg::card_pins_t  active_pins_in,
    // Card side
    output logic                           card_reset_out,
    output logic                           card_clock_out,
    output logic                           card_data_line_out,
    output logic                           card_aux_line_a_out,
    output logic                           card_aux_line_b_out,
    output logic                           card_supply_out,
    output logic                           deact_busy_out
);

    // ------------------------------------------------------------
    // Constants and state
    // ------------------------------------------------------------
    localparam int unsigned RC_W = 8;
    localparam logic [RC_W-1:0] RST_CLK_LAST =
        RC_W'(`RST_TO_CLK_CYC - 1);

    card_seq_pkg::seq_state_t state_ff;
    card_seq_pkg::seq_state_t nxt_state;
    card_seq_pkg::fault_t     flt_meta_ff;
    card_seq_pkg::fault_t     flt_ff;
    logic                     req_meta_ff;
    logic                     req_n_ff;
    logic                     req_n_prev_ff;
    logic                     card_sync;
    logic                     card_ok;
    logic [RC_W-1:0]          dly_ff;
    logic                     event_n_ff;
    logic                     nxt_event_n;
    logic                     rst_ff;
    logic                     clk_ff;
    logic                     data_ff;
    logic                     aux_a_ff;
    logic                     aux_b_ff;
    logic                     sup_ff;
    logic                     any_fault;
    logic                     open_req;

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    // Fault reduction, extraction included
    function automatic logic fault_any(card_seq_pkg::fault_t f,
                                       logic present);
        fault_any = (|f) || !present;
    endfunction

    // Any state of the power-down walk, waiting included
    function automatic logic is_deact(card_seq_pkg::seq_state_t s);
        is_deact = (s != card_seq_pkg::ST_IDLE) &&
                   (s != card_seq_pkg::ST_ACTIVE);
    endfunction

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    // Two flops on the request and fault inputs; presence is synchronised in u_presence
    always_ff @(posedge core_clk_in)
    begin
        if (reset_in)
        begin
            req_meta_ff   <= 1'b1;
            req_n_ff      <= 1'b1;
            flt_meta_ff   <= '0;
            flt_ff        <= '0;
        end
        else
        begin
            req_meta_ff   <= session_request_n_in;
            req_n_ff      <= req_meta_ff;
            flt_meta_ff   <= fault_in;
            flt_ff        <= flt_meta_ff;
        end
    end

    // Previous synced request, idle high so no false edge
    always_ff @(posedge core_clk_in)
    begin
        if (reset_in)
            req_n_prev_ff <= 1'b1;
        else
            req_n_prev_ff <= req_n_ff;
    end

    sync_debounce #(
        .COUNT (DEBOUNCE_CYCLES),
        .CW    (DB_W)
    ) u_presence (
        .core_clk_in (core_clk_in),
        .reset_in    (reset_in),
        .level_in    (card_presence_switch_in),
        .sync_out    (card_sync),
        .stable_out  (card_ok)
    );

    assign any_fault = fault_any(flt_ff, card_sync);
    assign open_req  = req_n_prev_ff && !req_n_ff;

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            card_seq_pkg::ST_IDLE:
            begin
                // Edge only, a held-low request never reopens
                if (open_req && card_ok && !(|flt_ff))
                    nxt_state = card_seq_pkg::ST_ACTIVE;
            end
            card_seq_pkg::ST_ACTIVE:
            begin
                if (req_n_ff || any_fault)
                    nxt_state = card_seq_pkg::ST_RST_LOW;
            end
            card_seq_pkg::ST_RST_LOW:
            begin
                // wait 12 us after reset low
                if (dly_ff == RST_CLK_LAST)
                    nxt_state = card_seq_pkg::ST_CLK_LOW;
            end
            card_seq_pkg::ST_CLK_LOW:
                nxt_state = card_seq_pkg::ST_LINES_LOW;
            card_seq_pkg::ST_LINES_LOW:
                nxt_state = card_seq_pkg::ST_SUPPLY_OFF;
            card_seq_pkg::ST_SUPPLY_OFF:
            begin
                // Wait for host to release the request
                if (req_n_ff)
                    nxt_state = card_seq_pkg::ST_IDLE;
            end
            default:
                nxt_state = card_seq_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge core_clk_in)
    begin
        if (reset_in)
            state_ff <= card_seq_pkg::ST_IDLE;
        else
            state_ff <= nxt_state;
    end

    // Restarts on every entry to reset-low
    // reset to clock delay counter
    always_ff @(posedge core_clk_in)
    begin
        if (reset_in || state_ff != card_seq_pkg::ST_RST_LOW)
            dly_ff <= '0;
        else if (dly_ff != RST_CLK_LAST)
            dly_ff <= dly_ff + RC_W'(1);
    end

    // ------------------------------------------------------------
    // Card pin drivers
    // ------------------------------------------------------------
    // Levels follow the next state, one step per edge
    always_ff @(posedge core_clk_in)
    begin
        if (reset_in)
        begin
            rst_ff   <= `PIN_RST_VAL;
            clk_ff   <= `PIN_RST_VAL;
            data_ff  <= `PIN_RST_VAL;
            aux_a_ff <= `PIN_RST_VAL;
            aux_b_ff <= `PIN_RST_VAL;
            sup_ff   <= `PIN_RST_VAL;
        end
        else
        begin
            case (nxt_state)
                card_seq_pkg::ST_ACTIVE:
                begin
                    rst_ff   <= active_pins_in.reset;
                    clk_ff   <= active_pins_in.clock;
                    data_ff  <= active_pins_in.data;
                    aux_a_ff <= active_pins_in.aux_a;
                    aux_b_ff <= active_pins_in.aux_b;
                    sup_ff   <= active_pins_in.supply;
                end
                card_seq_pkg::ST_RST_LOW:
                    rst_ff <= 1'b0;
                card_seq_pkg::ST_CLK_LOW:
                begin
                    rst_ff <= 1'b0;
                    clk_ff <= 1'b0;
                end
                card_seq_pkg::ST_LINES_LOW:
                begin
                    rst_ff   <= 1'b0;
                    clk_ff   <= 1'b0;
                    data_ff  <= 1'b0;
                    aux_a_ff <= 1'b0;
                    aux_b_ff <= 1'b0;
                end
                default:
                begin
                    rst_ff   <= 1'b0;
                    clk_ff   <= 1'b0;
                    data_ff  <= 1'b0;
                    aux_a_ff <= 1'b0;
                    aux_b_ff <= 1'b0;
                    sup_ff   <= 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Event output
    // ------------------------------------------------------------
    always_comb
    begin
        nxt_event_n = card_ok && !flt_ff.logic_uv;
        if (state_ff == card_seq_pkg::ST_ACTIVE)
        begin
            if (any_fault)
                nxt_event_n = 1'b0;
        end
        else if (is_deact(state_ff))
        begin
            if (!event_n_ff || any_fault)
                nxt_event_n = 1'b0;
        end
    end

    always_ff @(posedge core_clk_in)
    begin
        if (reset_in)
            event_n_ff <= `EVENT_RST_VAL;
        else
            event_n_ff <= nxt_event_n;
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign event_n_out         = event_n_ff;
    assign card_reset_out      = rst_ff;
    assign card_clock_out      = clk_ff;
    assign card_data_line_out  = data_ff;
    assign card_aux_line_a_out = aux_a_ff;
    assign card_aux_line_b_out = aux_b_ff;
    assign card_supply_out     = sup_ff;
    assign deact_busy_out      = is_deact(state_ff);

endmodule

/* hw/card_seq_consts.svh */
// Purpose: Timing counts and reset values for the card sequencer
// Assumes: Core clock of 10 MHz (100 ns period)
// Notes:   Times kept in their own units, cycle counts derived
`ifndef CARD_SEQ_CONSTS_SVH
`define CARD_SEQ_CONSTS_SVH

// ----------------------------------------------------------------
// Clock
// ----------------------------------------------------------------
`define CORE_CLK_HZ          10000000
`define CORE_CLK_PERIOD_NS   100

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
// Reset low to clock low, least time
`define RST_TO_CLK_US        12
`define RST_TO_CLK_CYC       ((`RST_TO_CLK_US * 1000 + \
                              `CORE_CLK_PERIOD_NS - 1) / \
                              `CORE_CLK_PERIOD_NS)
// Insertion debounce, nominal
`define DEBOUNCE_MS          8
`define DEBOUNCE_CYC         ((`DEBOUNCE_MS * 1000000) / \
                              `CORE_CLK_PERIOD_NS)
// One cycle per remaining deactivation step
`define STEP_CYC             1

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define EVENT_RST_VAL        1'b0
`define PIN_RST_VAL          1'b0

`endif

/* hw/card_seq_pkg.sv */
// Purpose: Types shared by the card sequencer files
// Assumes: Nothing beyond the constants header
// Notes:   Holds types only
package card_seq_pkg;

    // Sequencer states
    typedef enum logic [2:0]
    {
        ST_IDLE,
        ST_ACTIVE,
        ST_RST_LOW,
        ST_CLK_LOW,
        ST_LINES_LOW,
        ST_SUPPLY_OFF
    } seq_state_t;

    // Fault inputs, asynchronous, synchronised by two flops inside card_seq
    typedef struct packed
    {
        logic logic_uv;
        logic supply_overload;
        logic supply_out_of_range;
        logic conv_in_uv;
        logic boost_overload;
        logic over_temp;
    } fault_t;

    // Requests from the activation logic to the card pins
    typedef struct packed
    {
        logic reset;
        logic clock;
        logic data;
        logic aux_a;
        logic aux_b;
        logic supply;
    } card_pins_t;

endpackage

/* hw/sync_debounce.sv */
// Purpose: Two-flop synchroniser with a stable-high debounce timer
// Assumes: Input comes from a pin outside the clock domain
// Notes:   Rise is delayed by the full count, fall passes at once
`timescale 1ns/10ps
`include "card_seq_consts.svh"

module sync_debounce #(
    parameter int unsigned COUNT = `DEBOUNCE_CYC,
    parameter int unsigned CW    = 20
)(
    // Clock and reset
    input  wire logic core_clk_in,
    input  wire logic reset_in,
    // Raw and filtered level
    input  wire logic level_in,
    output logic      sync_out,
    output logic      stable_out
);

    logic          meta_ff;
    logic          sync_ff;
    logic [CW-1:0] cnt_ff;
    logic          stable_ff;

    // ------------------------------------------------------------
    // Synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_in)
    begin
        if (reset_in)
        begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
        end
        else
        begin
            meta_ff <= level_in;
            sync_ff <= meta_ff;
        end
    end

    // ------------------------------------------------------------
    // Debounce
    // ------------------------------------------------------------
    // insertion debounce timer
    always_ff @(posedge core_clk_in)
    begin
        if (reset_in || !sync_ff)
        begin
            cnt_ff    <= '0;
            stable_ff <= 1'b0;
        end
        else if (cnt_ff >= CW'(COUNT - 1))
            stable_ff <= 1'b1;
        else
            cnt_ff <= cnt_ff + CW'(1);
    end

    assign sync_out   = sync_ff;
    assign stable_out = stable_ff;

endmodule
